// ### design/ucf_usart_core.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ucf_usart_core (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire ucf_pkg::ucf_bus_req_s     bus_i,
   output var  logic [ucf_pkg::DATA_W-1:0] rdata_o,
   input  wire logic                      rxd_i,
   output var  logic                      txd_o,
   input  wire logic                      xck_i,
   output var  logic                      xck_o,
   output var  logic                      xck_oe_o
);
   import ucf_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0]   rdata;
      logic                txd;
      logic                sync_clock_pin;
      logic                xck_oe;
      logic                u2x;
      logic                rxen;
      logic                txen;
      logic                txb8;
      logic                umsel;
      logic                usbs;
      logic                ucpol;
      logic                dir;
      logic [2:0]          csz;
      logic [1:0]          upm;
      logic [DIV_W-1:0]    div;
      logic [DIV_W-1:0]    cnt;
      logic [1:0]          rxd_sync;
      logic [2:0]          xck_sync;
      logic [3:0]          tx_div;
      ucf_tx_e             tx_st;
      logic [8:0]          tx_sh;
      logic [3:0]          tx_n;
      logic                tx_par;
      logic                tx_full;
      logic [8:0]          tx_buf;
      logic [3:0]          rx_div;
      ucf_rx_e             rx_st;
      logic [8:0]          rx_sh;
      logic [3:0]          rx_n;
      logic                rx_par;
      logic                rx_pe;
      logic                rx_hold;
      logic                rx_arm;
      ucf_rx_entry_s       rx_held;
      logic                dor_pend;
      ucf_rx_entry_s [1:0] fifo;
      logic                wp;
      logic                rp;
      logic [1:0]          fcnt;
   } ucf_state_s;

   ucf_state_s    q;
   ucf_state_s    s;
   logic          tick;
   logic          sync;
   logic          master;
   logic          rise;
   logic          fall;
   logic          chg_edge;
   logic          smp_edge;
   logic          tx_bit;
   logic          tx_go;
   logic          rx_samp;
   logic          rxd;
   logic [3:0]    last;
   logic [3:0]    mid;
   logic [3:0]    bits;
   logic [3:0]    nxt;
   logic          pop;
   logic          push;
   logic          wr;
   logic          rd;
   ucf_rx_entry_s ent;
   ucf_rx_entry_s head;
   logic [7:0]    rv;

   always_comb begin
      s        = q;
      wr       = bus_i.we;
      rd       = bus_i.re;
      tx_go    = 1'b0;
      push     = 1'b0;
      ent      = '0;
      rv       = 8'h00;
      head     = q.fifo[q.rp];
      bits     = char_bits(q.csz);
      nxt      = 4'h0;
      rxd      = q.rxd_sync[1];

      //////////////////////////////////////////////////////////////////
      // input synchronisers
      s.rxd_sync = {q.rxd_sync[0], rxd_i};
      s.xck_sync = {q.xck_sync[1:0], xck_i};

      //////////////////////////////////////////////////////////////////
      // baud generator
      tick = (q.cnt == 12'h000);
      if (wr && bus_i.addr == OFF_DIVL) begin
         s.cnt = {q.div[11:8], bus_i.wdata};
      end else if (tick) begin
         s.cnt = q.div;
      end else begin
         s.cnt = q.cnt - 12'h001;
      end

      //////////////////////////////////////////////////////////////////
      // clock mode and sync clock edges
      sync     = q.umsel;
      master   = sync && q.dir;
      s.xck_oe = master;
      if (!master) begin
         s.sync_clock_pin = 1'b0;
      end else if (tick) begin
         s.sync_clock_pin = ~q.sync_clock_pin;
      end
      if (master) begin
         rise = tick && !q.sync_clock_pin;
         fall = tick && q.sync_clock_pin;
      end else begin
         rise = q.xck_sync[1] && !q.xck_sync[2];
         fall = !q.xck_sync[1] && q.xck_sync[2];
      end
      chg_edge = q.ucpol ? fall : rise;
      smp_edge = q.ucpol ? rise : fall;
      last = q.u2x ? LAST_DOUBLE : LAST_NORMAL;
      mid  = q.u2x ? MID_DOUBLE : MID_NORMAL;

      //////////////////////////////////////////////////////////////////
      // transmitter
      if (tick) begin
         s.tx_div = (q.tx_div >= last) ? 4'h0 : q.tx_div + 4'h1;
      end
      tx_bit = sync ? chg_edge : (tick && q.tx_div >= last);
      if (tx_bit) begin
         unique case (q.tx_st)
            TX_IDLE: begin
               tx_go = 1'b1;
            end
            TX_START: begin
               s.txd    = q.tx_sh[0];
               s.tx_sh  = {1'b0, q.tx_sh[8:1]};
               s.tx_par = q.tx_par ^ q.tx_sh[0];
               s.tx_n   = 4'h1;
               s.tx_st  = TX_DATA;
            end
            TX_DATA: begin
               if (q.tx_n == bits) begin
                  if (q.upm[1]) begin
                     s.txd   = q.tx_par;
                     s.tx_st = TX_PAR;
                  end else begin
                     s.txd   = 1'b1;
                     s.tx_st = TX_STOP1;
                  end
               end else begin
                  s.txd    = q.tx_sh[0];
                  s.tx_sh  = {1'b0, q.tx_sh[8:1]};
                  s.tx_par = q.tx_par ^ q.tx_sh[0];
                  s.tx_n   = q.tx_n + 4'h1;
               end
            end
            TX_PAR: begin
               s.txd   = 1'b1;
               s.tx_st = TX_STOP1;
            end
            TX_STOP1: begin
               if (q.usbs) begin
                  s.tx_st = TX_STOP2;
               end else begin
                  tx_go = 1'b1;
               end
            end
            TX_STOP2: begin
               tx_go = 1'b1;
            end
            default: begin
               s.tx_st = TX_IDLE;
               s.txd   = 1'b1;
            end
         endcase
      end
      if (tx_go) begin
         if (q.tx_full && q.txen) begin
            s.txd     = 1'b0;
            s.tx_sh   = q.tx_buf;
            s.tx_full = 1'b0;
            s.tx_par  = (q.upm == PAR_ODD);
            s.tx_st   = TX_START;
         end else begin
            s.txd   = 1'b1;
            s.tx_st = TX_IDLE;
         end
      end

      //////////////////////////////////////////////////////////////////
      // receiver
      if (tick && q.rx_st != RX_IDLE) begin
         s.rx_div = (q.rx_div >= last) ? 4'h0 : q.rx_div + 4'h1;
      end
      rx_samp = sync ? smp_edge : (tick && q.rx_div == mid);
      pop = rd && bus_i.addr == OFF_DATA && q.fcnt != 2'h0;
      nxt = q.rx_n + 4'h1;
      unique case (q.rx_st)
         RX_IDLE: begin
            if (rxd) begin
               s.rx_arm = 1'b1;
            end
            if (q.rxen && q.rx_arm && !rxd && (sync ? smp_edge : tick)) begin
               s.rx_div = 4'h1;
               s.rx_n   = 4'h0;
               s.rx_par = (q.upm == PAR_ODD);
               s.rx_pe  = 1'b0;
               s.rx_st  = sync ? RX_DATA : RX_START;
               if (q.rx_hold && !pop) begin
                  s.rx_hold  = 1'b0;
                  s.dor_pend = 1'b1;
               end
            end
         end
         RX_START: begin
            if (rx_samp) begin
               s.rx_st = rxd ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (rx_samp) begin
               s.rx_sh  = {rxd, q.rx_sh[8:1]};
               s.rx_par = q.rx_par ^ rxd;
               s.rx_n   = nxt;
               if (nxt == bits) begin
                  s.rx_st = q.upm[1] ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR: begin
            if (rx_samp) begin
               s.rx_pe = q.rx_par ^ rxd;
               s.rx_st = RX_STOP;
            end
         end
         RX_STOP: begin
            if (rx_samp) begin
               ent.data   = q.rx_sh >> (4'h9 - bits);
               ent.fe     = !rxd;
               ent.dor    = q.dor_pend;
               ent.pe     = q.rx_pe;
               s.dor_pend = 1'b0;
               s.rx_arm   = rxd;
               s.rx_st    = RX_IDLE;
               if (q.fcnt != 2'h2 || pop) begin
                  push = 1'b1;
               end else begin
                  s.rx_hold = 1'b1;
                  s.rx_held = ent;
               end
            end
         end
         default: begin
            s.rx_st = RX_IDLE;
         end
      endcase
      if (q.rx_hold && pop) begin
         ent       = q.rx_held;
         push      = 1'b1;
         s.rx_hold = 1'b0;
      end

      //////////////////////////////////////////////////////////////////
      // receive fifo
      if (push) begin
         s.fifo[q.wp] = ent;
         s.wp         = ~q.wp;
      end
      if (pop) begin
         s.rp = ~q.rp;
      end
      s.fcnt = q.fcnt + {1'b0, push} - {1'b0, pop};

      //////////////////////////////////////////////////////////////////
      // register writes
      if (wr) begin
         unique case (bus_i.addr)
            OFF_DATA: begin
               s.tx_buf  = {q.txb8, bus_i.wdata};
               s.tx_full = 1'b1;
            end
            OFF_CSA: s.u2x = bus_i.wdata[CSA_U2X];
            OFF_CSB: begin
               s.rxen   = bus_i.wdata[CSB_RXEN];
               s.txen   = bus_i.wdata[CSB_TXEN];
               s.csz[2] = bus_i.wdata[CSB_CSZ2];
               s.txb8   = bus_i.wdata[CSB_TXB8];
            end
            OFF_CSC: begin
               s.umsel    = bus_i.wdata[CSC_UMSEL];
               s.upm      = bus_i.wdata[CSC_UPM+1:CSC_UPM];
               s.usbs     = bus_i.wdata[CSC_USBS];
               s.csz[1:0] = bus_i.wdata[CSC_CSZ+1:CSC_CSZ];
               s.ucpol    = bus_i.wdata[CSC_UCPOL];
            end
            OFF_DIVL: s.div[7:0]  = bus_i.wdata;
            OFF_DIVH: s.div[11:8] = bus_i.wdata[3:0];
            OFF_PIN:  s.dir       = bus_i.wdata[PIN_DIR];
            default: begin
            end
         endcase
      end

      //////////////////////////////////////////////////////////////////
      // register reads, data valid next cycle only
      if (rd) begin
         unique case (bus_i.addr)
            OFF_DATA: rv = (q.fcnt != 2'h0) ? head.data[7:0] : 8'h00;
            OFF_CSA: begin
               rv[CSA_RXC] = (q.fcnt != 2'h0);
               rv[CSA_TXE] = !q.tx_full;
               rv[CSA_FE]  = (q.fcnt != 2'h0) && head.fe;
               rv[CSA_DOR] = (q.fcnt != 2'h0) && head.dor;
               rv[CSA_PE]  = (q.fcnt != 2'h0) && head.pe;
               rv[CSA_U2X] = q.u2x;
            end
            OFF_CSB: begin
               rv[CSB_RXEN] = q.rxen;
               rv[CSB_TXEN] = q.txen;
               rv[CSB_CSZ2] = q.csz[2];
               rv[CSB_RXB8] = (q.fcnt != 2'h0) && head.data[8];
               rv[CSB_TXB8] = q.txb8;
            end
            OFF_CSC: begin
               rv[CSC_UMSEL]             = q.umsel;
               rv[CSC_UPM+1:CSC_UPM]     = q.upm;
               rv[CSC_USBS]              = q.usbs;
               rv[CSC_CSZ+1:CSC_CSZ]     = q.csz[1:0];
               rv[CSC_UCPOL]             = q.ucpol;
            end
            OFF_DIVL: rv = q.div[7:0];
            OFF_DIVH: rv = {4'h0, q.div[11:8]};
            OFF_PIN:  rv[PIN_DIR] = q.dir;
            default:  rv = 8'h00;
         endcase
      end
      s.rdata = rv;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q          <= '0;
         q.txd      <= 1'b1;
         q.csz      <= RST_CSZ;
         q.upm      <= PAR_NONE;
         q.div      <= RST_DIV;
         q.rxd_sync <= 2'h3;
         q.tx_st    <= TX_IDLE;
         q.rx_st    <= RX_IDLE;
      end else begin
         q <= s;
      end
   end

   assign rdata_o  = q.rdata;
   assign txd_o    = q.txd;
   assign xck_o    = q.sync_clock_pin;
   assign xck_oe_o = q.xck_oe;

endmodule : ucf_usart_core
`default_nettype wire

// ### pkg/ucf_pkg.sv
`default_nettype none
package ucf_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int DIV_W  = 12;

   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [ADDR_W-1:0] OFF_DATA = 3'h0;
   localparam logic [ADDR_W-1:0] OFF_CSA  = 3'h1;
   localparam logic [ADDR_W-1:0] OFF_CSB  = 3'h2;
   localparam logic [ADDR_W-1:0] OFF_CSC  = 3'h3;
   localparam logic [ADDR_W-1:0] OFF_DIVL = 3'h4;
   localparam logic [ADDR_W-1:0] OFF_DIVH = 3'h5;
   localparam logic [ADDR_W-1:0] OFF_PIN  = 3'h6;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CSA_RXC = 7;
   localparam int CSA_TXE = 5;
   localparam int CSA_FE  = 4;
   localparam int CSA_DOR = 3;
   localparam int CSA_PE  = 2;
   localparam int CSA_U2X = 1;
   localparam int CSB_RXEN = 4;
   localparam int CSB_TXEN = 3;
   localparam int CSB_CSZ2 = 2;
   localparam int CSB_RXB8 = 1;
   localparam int CSB_TXB8 = 0;
   localparam int CSC_UMSEL = 6;
   localparam int CSC_UPM   = 4;
   localparam int CSC_USBS  = 3;
   localparam int CSC_CSZ   = 1;
   localparam int CSC_UCPOL = 0;
   localparam int PIN_DIR   = 0;

   ////////////////////////////////////////////////////////////////////////
   // reset values and codes
   localparam logic [2:0]       RST_CSZ  = 3'h3;
   localparam logic [DIV_W-1:0] RST_DIV  = 12'h000;
   localparam logic [1:0]       PAR_NONE = 2'h0;
   localparam logic [1:0]       PAR_EVEN = 2'h2;
   localparam logic [1:0]       PAR_ODD  = 2'h3;
   localparam logic [2:0]       CSZ_NINE = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // ticks per bit, last index and mid sample
   localparam logic [3:0] LAST_NORMAL = 4'hF;
   localparam logic [3:0] MID_NORMAL  = 4'h7;
   localparam logic [3:0] LAST_DOUBLE = 4'h7;
   localparam logic [3:0] MID_DOUBLE  = 4'h3;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_PAR   = 3'b011,
      TX_STOP1 = 3'b100,
      TX_STOP2 = 3'b101
   } ucf_tx_e;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100
   } ucf_rx_e;

   typedef struct packed {
      logic              we;
      logic              re;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ucf_bus_req_s;

   typedef struct packed {
      logic [8:0] data;
      logic       fe;
      logic       dor;
      logic       pe;
   } ucf_rx_entry_s;

   // data bits per character from the size code
   function automatic logic [3:0] char_bits(input logic [2:0] code);
      logic [3:0] n;
      n = 4'h8;
      case (code)
         3'h0:     n = 4'h5;
         3'h1:     n = 4'h6;
         3'h2:     n = 4'h7;
         CSZ_NINE: n = 4'h9;
         default:  n = 4'h8;
      endcase
      return n;
   endfunction : char_bits

endpackage : ucf_pkg
`default_nettype wire

// ### tb/ucf_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ucf_peer (
   input  wire logic clk_i,
   input  wire logic txd_i,
   output var  logic rxd_o
);
   initial rxd_o = 1'b1;

   // start low, data lsb first, given stop, then two idle bits high
   task automatic send(input int bt, input int n, input logic [8:0] d,
                       input logic sp);
      for (int i = 0; i < n + 4; i++) begin
         rxd_o <= (i == 0) ? 1'b0 : (i <= n) ? d[i-1] :
                  (i == n + 1) ? sp : 1'b1;
         repeat (bt) @(posedge clk_i);
      end
   endtask : send

   // mid-bit sampling of one frame from the transmit line
   task automatic get(input int bt, input int n, input logic pe,
                      output logic [8:0] d, output logic p, output logic ok);
      int i;
      d = '0;
      p = 1'b0;
      ok = 1'b0;
      for (i = 0; i < 400 && txd_i; i++) @(posedge clk_i);
      if (txd_i) return;
      repeat (bt / 2) @(posedge clk_i);
      ok = !txd_i;
      for (i = 0; i < n; i++) begin
         repeat (bt) @(posedge clk_i);
         d[i] = txd_i;
      end
      if (pe) begin
         repeat (bt) @(posedge clk_i);
         p = txd_i;
      end
      repeat (bt) @(posedge clk_i);
      ok = ok && txd_i;
   endtask : get
endmodule : ucf_peer
`default_nettype wire

// ### tb/ucf_usart_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ucf_usart_core_bench;
   import ucf_pkg::*;
   logic         clk_i = 1'b0;
   logic         rst_i;
   ucf_bus_req_s bus_i;
   logic [7:0]   rdata_o;
   logic         rxd_w;
   logic         txd_w;
   logic         xck_i;
   logic         xck_o;
   logic         xck_oe;
   int           n_fail = 0;
   int           total_checks = 0;

   ucf_usart_core i_ucf_usart_core (.clk_i(clk_i), .rst_i(rst_i),
      .bus_i(bus_i), .rdata_o(rdata_o), .rxd_i(rxd_w), .txd_o(txd_w),
      .xck_i(xck_i), .xck_o(xck_o), .xck_oe_o(xck_oe));
   ucf_peer i_ucf_peer (.clk_i(clk_i), .txd_i(txd_w), .rxd_o(rxd_w));

   always #4 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_i <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      bus_i <= '0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_i);
      bus_i <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      bus_i <= '0;
      #1 d = rdata_o;
   endtask : rd

   function automatic logic par(input logic [8:0] d, input int n,
                                input logic odd);
      logic r;
      r = odd;
      for (int i = 0; i < n; i++) r ^= d[i];
      return r;
   endfunction : par

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [2:0] ra [7] = '{OFF_CSA, OFF_CSB, OFF_CSC, OFF_DIVL, OFF_DIVH,
                             OFF_PIN, 3'h7};
      logic [7:0] rv [7] = '{8'h20, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] v;
      wr(3'h7, 8'h5A);
      for (int i = 0; i < 7; i++) begin
         rd(ra[i], v);
         chk({1'b0, v}, {1'b0, rv[i]});
      end
      wr(OFF_DIVH, 8'hFF);
      rd(OFF_DIVH, v);
      chk({1'b0, v}, 9'h00F);
      wr(OFF_DIVH, 8'h00);
      wr(OFF_DIVL, 8'h00);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_tx_formats;
      logic [7:0] fb [4] = '{8'h08, 8'h08, 8'h0D, 8'h08};
      logic [7:0] fc [4] = '{8'h06, 8'h2C, 8'h36, 8'h00};
      logic [8:0] fd [4] = '{9'h0A5, 9'h053, 9'h1C3, 9'h0F6};
      int         fn [4] = '{8, 7, 9, 5};
      logic [8:0] d;
      logic       p;
      logic       ok;
      for (int k = 0; k < 4; k++) begin
         wr(OFF_CSB, fb[k]);
         wr(OFF_CSC, fc[k]);
         wr(OFF_DATA, fd[k][7:0]);
         i_ucf_peer.get(16, fn[k], fc[k][5], d, p, ok);
         chk({8'h00, ok}, 9'h001);
         if (!ok) summarize();
         chk(d, fd[k] & ((9'h001 << fn[k]) - 9'h001));
         if (fc[k][5]) begin
            chk({8'h00, p}, {8'h00, par(fd[k], fn[k], fc[k][4])});
         end
         repeat (40) @(posedge clk_i);
      end
      $display("t_tx_formats done");
   endtask : t_tx_formats

   task automatic t_tx_double;
      logic [8:0] d;
      logic       p;
      logic       ok;
      wr(OFF_CSA, 8'h02);
      wr(OFF_DIVH, 8'h00);
      wr(OFF_DIVL, 8'h02);
      wr(OFF_CSC, 8'h06);
      wr(OFF_CSB, 8'h08);
      wr(OFF_DATA, 8'h3C);
      i_ucf_peer.get(24, 8, 1'b0, d, p, ok);
      chk({8'h00, ok}, 9'h001);
      if (!ok) summarize();
      chk(d, 9'h03C);
      repeat (60) @(posedge clk_i);
      wr(OFF_CSA, 8'h00);
      wr(OFF_DIVL, 8'h00);
      $display("t_tx_double done");
   endtask : t_tx_double

   task automatic t_rx;
      logic [8:0] c  [4] = '{9'h1A5, 9'h03C, 9'h155, 9'h0F0};
      logic       sp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
      int         ix [3] = '{0, 1, 3};
      logic [7:0] fl [3] = '{8'h80, 8'h90, 8'h88};
      logic [7:0] v;
      logic [7:0] b;
      wr(OFF_CSB, 8'h14);
      wr(OFF_CSC, 8'h06);
      for (int k = 0; k < 4; k++) begin
         i_ucf_peer.send(16, 9, c[k], sp[k]);
      end
      repeat (40) @(posedge clk_i);
      for (int k = 0; k < 3; k++) begin
         rd(OFF_CSA, v);
         chk({1'b0, v & 8'h98}, {1'b0, fl[k]});
         rd(OFF_CSB, b);
         rd(OFF_DATA, v);
         chk({b[CSB_RXB8], v}, c[ix[k]]);
      end
      rd(OFF_CSA, v);
      chk({8'h00, v[CSA_RXC]}, 9'h000);
      $display("t_rx done");
   endtask : t_rx

   task automatic t_sync;
      logic       a;
      logic [9:0] f;
      wr(OFF_PIN, 8'h01);
      wr(OFF_CSC, 8'h46);
      repeat (4) @(posedge clk_i);
      chk({8'h00, xck_oe}, 9'h001);
      @(posedge clk_i);
      #1 a = xck_o;
      @(posedge clk_i);
      #1 chk({8'h00, a ^ xck_o}, 9'h001);
      wr(OFF_PIN, 8'h00);
      for (int i = 0; i < 8; i++) begin
         repeat (4) @(posedge clk_i);
         xck_i <= ~xck_i;
      end
      chk({7'h00, xck_oe, xck_o}, 9'h000);
      wr(OFF_CSB, 8'h08);
      wr(OFF_DATA, 8'hB4);
      for (int j = 0; j < 10; j++) begin
         xck_i <= 1'b1;
         repeat (4) @(posedge clk_i);
         xck_i <= 1'b0;
         f[j] = txd_w;
         repeat (4) @(posedge clk_i);
      end
      chk({1'b0, f[8:1]}, 9'h0B4);
      chk({7'h00, f[9], f[0]}, 9'h002);
      wr(OFF_CSC, 8'h06);
      repeat (4) @(posedge clk_i);
      chk({7'h00, xck_oe, xck_o}, 9'h000);
      $display("t_sync done");
   endtask : t_sync

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_i = 1'b1;
      bus_i = '0;
      xck_i = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_tx_formats();
      t_tx_double();
      t_rx();
      t_sync();
      summarize();
   end
endmodule : ucf_usart_core_bench
`default_nettype wire

// ### tb/ucf_usart_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module ucf_usart_core_props
   import ucf_pkg::*;
(
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire ucf_pkg::ucf_bus_req_s      bus_i,
   input wire logic [ucf_pkg::DATA_W-1:0] rdata_o,
   input wire logic                       rxd_i,
   input wire logic                       txd_o,
   input wire logic                       xck_i,
   input wire logic                       xck_o,
   input wire logic                       xck_oe_o
);
   logic        umsel_q;
   logic        dir_q;
   logic        u2x_q;
   logic [7:0]  divl_q;
   logic [3:0]  divh_q;
   logic [15:0] low_q;
   logic        mst;
   logic        div0;
   int          bit_len;

   ////////////////////////////////////////////////////////////////////////
   // shadow of configuration written over the bus
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         umsel_q <= 1'b0;
         dir_q   <= 1'b0;
         u2x_q   <= 1'b0;
         divl_q  <= 8'h00;
         divh_q  <= 4'h0;
      end else if (bus_i.we) begin
         if (bus_i.addr == OFF_CSC) umsel_q <= bus_i.wdata[CSC_UMSEL];
         if (bus_i.addr == OFF_PIN) dir_q <= bus_i.wdata[PIN_DIR];
         if (bus_i.addr == OFF_CSA) u2x_q <= bus_i.wdata[CSA_U2X];
         if (bus_i.addr == OFF_DIVL) divl_q <= bus_i.wdata;
         if (bus_i.addr == OFF_DIVH) divh_q <= bus_i.wdata[3:0];
      end
   end

   // length of the current low run on the transmit line
   always_ff @(posedge clk_i) begin
      if (rst_i || txd_o) begin
         low_q <= 16'h0000;
      end else begin
         low_q <= low_q + 16'h0001;
      end
   end

   assign mst     = umsel_q && dir_q;
   assign div0    = {divh_q, divl_q} == 12'h000;
   assign bit_len = (u2x_q ? 8 : 16) * (int'({divh_q, divl_q}) + 1);

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_master;
      mst [*3];
   endsequence
   sequence s_no_master;
      (!mst) [*3];
   endsequence

   a_rdata_quiet: assert property (!bus_i.re |=> rdata_o == '0)
      else $error("read data without a read strobe");
   a_unmapped_zero: assert property (
      bus_i.re && bus_i.addr == 3'h7 |=> rdata_o == '0)
      else $error("unmapped read not zero");
   a_reset_idle: assert property (
      $fell(rst_i) |-> txd_o && !xck_oe_o && !xck_o && rdata_o == '0)
      else $error("outputs not idle after reset");
   a_pin_off: assert property (s_no_master |-> !xck_oe_o && !xck_o)
      else $error("clock pin driven outside master mode");
   a_pin_on: assert property (s_master |-> xck_oe_o)
      else $error("clock pin not driven in master mode");
   a_xck_toggle: assert property (
      (mst && div0) [*3] |=> $changed(xck_o))
      else $error("master clock not toggling every tick");
   a_bit_len: assert property (
      $rose(txd_o) && !umsel_q |-> int'(low_q) % bit_len == 0)
      else $error("low run not a whole number of bit times");
   a_start_min: assert property (
      $fell(txd_o) && !umsel_q && !u2x_q && div0
      |=> (!txd_o) [*8] ##1 (!txd_o) [*7])
      else $error("low bit shorter than sixteen clocks");
endmodule : ucf_usart_core_props

bind ucf_usart_core ucf_usart_core_props i_ucf_usart_core_props (
   .clk_i    (clk_i),
   .rst_i    (rst_i),
   .bus_i    (bus_i),
   .rdata_o  (rdata_o),
   .rxd_i    (rxd_i),
   .txd_o    (txd_o),
   .xck_i    (xck_i),
   .xck_o    (xck_o),
   .xck_oe_o (xck_oe_o)
);
`default_nettype wire
